// *** drbc_regs.vh ***
// Register offsets, field positions, reset values and timing figures of the refresh and backup controller
`ifndef DRBC_REGS_VH
`define DRBC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define DRBC_REG_CTRL 4'h0
`define DRBC_REG_UPPER 4'h1
`define DRBC_REG_STATUS 4'h2
`define DRBC_REG_ABORTS 4'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DRBC_CTRL_EN 0
`define DRBC_CTRL_BURST 1
`define DRBC_CTRL_ABORT 2
`define DRBC_ST_BACKUP 0
`define DRBC_ST_GUARD 1
`define DRBC_ST_PRETRIG 2
`define DRBC_ST_STROBE 3
`define DRBC_ST_WRBACK 4
`define DRBC_ST_PEND 5
`define DRBC_ST_ADDR_LO 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DRBC_CTRL_RST 1'h0
`define DRBC_UPPER_RST 7'h00

// ----------------------------------------------------------------
// Array geometry and timing figures
// ----------------------------------------------------------------
`define DRBC_ROWS 6'h20
`define DRBC_CLK_PS 4000
`define DRBC_PRETRIG_NS 3000
`define DRBC_STROBE_NS 500
`define DRBC_RW_DELAY_NS 250
`define DRBC_DIST_NS 62500
`define DRBC_BURST_NS 2000000
`define DRBC_DIST_CYC 20'h03D09
`define DRBC_BURST_CYC 20'h7A120
`define DRBC_PRE_CYC 16'h02EE
`define DRBC_STB_CYC 16'h007D
`define DRBC_RW_CYC 16'h003F

`endif

// *** drbc_sync2.v ***
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps

module drbc_sync2
(
    input wire clk_i,
    input wire rstn_i,
    input wire d_i,
    output wire q_o
);

    reg meta_q;
    reg sync_q;

    // First stage feeds only the second stage
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule // drbc_sync2

// *** drbc_oneshot.v ***
// Retriggerable-free one-shot pulse timer with cancel
`timescale 1ns/1ps

module drbc_oneshot #(
    parameter [15:0] LEN = 16'h0001
)
(
    input wire clk_i,
    input wire rstn_i,
    input wire trig_i,
    input wire cancel_i,
    output wire active_o,
    output wire done_o,
    output wire [15:0] left_o
);

    reg active_q;
    reg [15:0] cnt_q;

    // Count the pulse down; a trigger while running is ignored
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            active_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else if (active_q)
        begin
            if (cancel_i || cnt_q == 16'h0000)
                active_q <= 1'b0;
            else
                cnt_q <= cnt_q - 16'h0001;
        end
        else if (trig_i)
        begin
            active_q <= 1'b1;
            cnt_q <= LEN - 16'h0001;
        end
    end

    assign active_o = active_q;
    assign done_o = active_q && !cancel_i && (cnt_q == 16'h0000); // Natural end only
    assign left_o = cnt_q;

endmodule // drbc_oneshot

// *** drbc_top.v ***
// Refresh scheduler and battery-backup changeover controller for a two-bank dynamic RAM array
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "drbc_regs.vh"

module drbc_top #(
    parameter [19:0] DIST_CYC = `DRBC_DIST_CYC,
    parameter [19:0] BURST_CYC = `DRBC_BURST_CYC
)
(
    input wire clk_i,
    input wire rstn_i,
    input wire [3:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output wire [15:0] reg_rdata_o,
    input wire power_fail_i,
    input wire mem_clk_i,
    input wire bank_sel_i,
    output wire mem_hold_o,
    output wire backup_o,
    output wire backup_n_o,
    output wire [4:0] low_row_address_o,
    output wire [6:0] upper_address_o,
    output wire refresh_drive_o,
    output wire cs_n_o,
    output wire rw_n_o,
    output wire bank0_cycle_strobe_o,
    output wire bank1_cycle_strobe_o,
    output wire standby_drv_oe_o,
    output wire mem_drv_oe_o
);

    // ----------------------------------------------------------------
    // Derived cycle counts
    // ----------------------------------------------------------------
    localparam [15:0] PRE_CYC = `DRBC_PRE_CYC;
    localparam [15:0] STB_CYC = `DRBC_STB_CYC;
    localparam [15:0] RW_CYC = `DRBC_RW_CYC;
    localparam [15:0] RW_LEFT = STB_CYC - RW_CYC;

    // Next value of a wrapping five-bit address
    function [4:0] drbc_inc5;
        input [4:0] a;
        begin
            drbc_inc5 = a + 5'h01;
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg en_q;
    reg burst_q;
    reg abort_q;
    reg [6:0] upper_q;
    reg [7:0] aborts_q;
    reg [15:0] rdata_q;
    reg [19:0] div_q;
    reg pend_q;
    reg [5:0] left_q;
    reg [4:0] raddr_q;
    reg guard_q;
    reg backup_q;
    reg mc_d_q;
    reg hold_q;
    reg drive_q;
    reg cs_n_q;
    reg rw_n_q;
    reg bank0_q;
    reg bank1_q;
    reg stby_oe_q;
    reg mem_oe_q;
    wire pf_s;
    wire mc_s;
    wire bs_s;
    wire mc_rise;
    wire tick;
    wire start;
    wire pre_act;
    wire pre_done;
    wire stb_act;
    wire stb_done;
    wire [15:0] stb_left;
    wire wrback;
    wire abort_ok;
    wire [19:0] period;
    wire stby_sel;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------

    // Power-fail, memory clock and bank select arrive from outside
    drbc_sync2 u_sync_pf (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(power_fail_i), .q_o(pf_s));
    drbc_sync2 u_sync_mc (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(mem_clk_i), .q_o(mc_s));
    drbc_sync2 u_sync_bs (.clk_i(clk_i), .rstn_i(rstn_i), .d_i(bank_sel_i), .q_o(bs_s));

    // Rising edge of the synchronised memory clock
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            mc_d_q <= 1'b0;
        else
            mc_d_q <= mc_s;
    end

    assign mc_rise = mc_s && !mc_d_q;

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------

    // Control writes; abort is a one-cycle request
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            en_q <= `DRBC_CTRL_RST;
            burst_q <= 1'b0;
            abort_q <= 1'b0;
            upper_q <= `DRBC_UPPER_RST;
        end
        else
        begin
            abort_q <= 1'b0;
            if (reg_we_i && reg_addr_i == `DRBC_REG_CTRL)
            begin
                en_q <= reg_wdata_i[`DRBC_CTRL_EN];
                burst_q <= reg_wdata_i[`DRBC_CTRL_BURST];
                abort_q <= reg_wdata_i[`DRBC_CTRL_ABORT];
            end
            if (reg_we_i && reg_addr_i == `DRBC_REG_UPPER)
                upper_q <= reg_wdata_i[6:0];
        end
    end

    // Read data stand in the cycle after the strobe; unmapped reads give zero
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            rdata_q <= 16'h0000;
        else if (reg_re_i)
        begin
            case (reg_addr_i)
                `DRBC_REG_CTRL: rdata_q <= {14'h0000, burst_q, en_q};
                `DRBC_REG_UPPER: rdata_q <= {9'h000, upper_q};
                `DRBC_REG_STATUS: rdata_q <= {3'h0, raddr_q, 2'h0, pend_q, wrback, stb_act,
                                              pre_act, guard_q, backup_q};
                `DRBC_REG_ABORTS: rdata_q <= {8'h00, aborts_q};
                default: rdata_q <= 16'h0000;
            endcase
        end
        else
            rdata_q <= 16'h0000;
    end

    // ----------------------------------------------------------------
    // Refresh clock divider and request scheduling
    // ----------------------------------------------------------------
    assign period = burst_q ? BURST_CYC : DIST_CYC;
    assign tick = en_q && (div_q == 20'h00000);

    // Interval counter; restarts while disabled
    always @(posedge clk_i)
    begin
        if (!rstn_i || !en_q)
            div_q <= 20'h00000;
        else if (div_q >= period - 20'h00001)
            div_q <= 20'h00000;
        else
            div_q <= div_q + 20'h00001;
    end

    // Pending request and burst remainder; a new request wins over the take
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pend_q <= 1'b0;
            left_q <= 6'h00;
        end
        else
        begin
            if (stb_done && left_q != 6'h00)
                left_q <= left_q - 6'h01;
            if (tick && burst_q)
                left_q <= `DRBC_ROWS;
            if (tick || (stb_done && left_q > 6'h01))
                pend_q <= 1'b1;
            else if (start)
                pend_q <= 1'b0;
        end
    end

    assign start = pend_q && !pre_act && !stb_act;

    // ----------------------------------------------------------------
    // Pretrigger and standby strobe one-shots
    // ----------------------------------------------------------------
    drbc_oneshot #(.LEN(PRE_CYC)) u_pretrig (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .trig_i(start),
        .cancel_i(abort_ok),
        .active_o(pre_act),
        .done_o(pre_done),
        .left_o()
    );

    drbc_oneshot #(.LEN(STB_CYC)) u_strobe (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .trig_i(pre_done),
        .cancel_i(abort_ok),
        .active_o(stb_act),
        .done_o(stb_done),
        .left_o(stb_left)
    );

    // Write strobe falls part way into the strobe; from then the cycle runs out
    assign wrback = stb_act && (stb_left < RW_LEFT);
    assign abort_ok = abort_q && (pre_act || (stb_act && !wrback));

    // ----------------------------------------------------------------
    // Guard, backup flag and refresh address
    // ----------------------------------------------------------------

    // Guard set by the pretrigger, cleared at strobe end or abort
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            guard_q <= 1'b0;
        else if (start || pre_act)
            guard_q <= 1'b1;
        else if (stb_done || abort_ok || !stb_act)
            guard_q <= 1'b0;
    end

    // J-K stage: J is power-fail, K its complement, clocked by memory clock
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            backup_q <= 1'b0;
        else if (mc_rise && !guard_q && !start)
        begin
            if (pf_s)
                backup_q <= 1'b1;
            else
                backup_q <= 1'b0;
        end
    end

    // Address counter steps only after a completed cycle
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            raddr_q <= 5'h00;
        else if (stb_done)
            raddr_q <= drbc_inc5(raddr_q);
    end

    // Count of aborted refresh cycles
    always @(posedge clk_i)
    begin
        if (!rstn_i)
            aborts_q <= 8'h00;
        else if (abort_ok && aborts_q != 8'hFF)
            aborts_q <= aborts_q + 8'h01;
    end

    // ----------------------------------------------------------------
    // Array pins
    // ----------------------------------------------------------------
    assign stby_sel = backup_q || stb_act;

    // All pin outputs but backup_n_o, an inverted copy of backup_o, come from flip-flops
    always @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            hold_q <= 1'b0;
            drive_q <= 1'b0;
            cs_n_q <= 1'b1;
            rw_n_q <= 1'b1;
            bank0_q <= 1'b0;
            bank1_q <= 1'b0;
            stby_oe_q <= 1'b0;
            mem_oe_q <= 1'b0;
        end
        else
        begin
            hold_q <= pre_act || stb_act;
            drive_q <= pre_act || stb_act;
            cs_n_q <= 1'b1;
            rw_n_q <= !wrback;
            stby_oe_q <= stby_sel;
            mem_oe_q <= !stby_sel;
            if (stby_sel)
            begin
                bank0_q <= stb_act;
                bank1_q <= stb_act;
            end
            else
            begin
                bank0_q <= mc_s && !bs_s;
                bank1_q <= mc_s && bs_s;
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign mem_hold_o = hold_q;
    assign backup_o = backup_q;
    assign backup_n_o = !backup_q;
    assign low_row_address_o = raddr_q;
    assign upper_address_o = upper_q;
    assign refresh_drive_o = drive_q;
    assign cs_n_o = cs_n_q;
    assign rw_n_o = rw_n_q;
    assign bank0_cycle_strobe_o = bank0_q;
    assign bank1_cycle_strobe_o = bank1_q;
    assign standby_drv_oe_o = stby_oe_q;
    assign mem_drv_oe_o = mem_oe_q;

endmodule // drbc_top

// *** drbc_chk_properties.sv ***
// Port-level checks of the refresh and backup controller
`timescale 1ns/1ps

module drbc_chk
(
    input wire clk_i,
    input wire rstn_i,
    input wire reg_re_i,
    input wire [15:0] reg_rdata_o,
    input wire mem_hold_o,
    input wire backup_o,
    input wire backup_n_o,
    input wire [4:0] low_row_address_o,
    input wire [6:0] upper_address_o,
    input wire refresh_drive_o,
    input wire cs_n_o,
    input wire rw_n_o,
    input wire bank0_cycle_strobe_o,
    input wire standby_drv_oe_o,
    input wire mem_drv_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    reg [11:0] hold_q;
    // Length of the current hold stretch
    always @(posedge clk_i)
        if (!rstn_i || !mem_hold_o)
            hold_q <= 12'h000;
        else
            hold_q <= hold_q + 12'h001;

    property p_sel; cs_n_o; endproperty
    a_sel: assert property (p_sel) else $error("select not inactive");
    property p_upper; refresh_drive_o && $past(refresh_drive_o) |-> $stable(upper_address_o); endproperty
    a_upper: assert property (p_upper) else $error("upper address moved");
    property p_bat; backup_n_o != backup_o; endproperty
    a_bat: assert property (p_bat) else $error("backup pair equal");
    property p_drv; $past(rstn_i) |-> standby_drv_oe_o != mem_drv_oe_o; endproperty
    a_drv: assert property (p_drv) else $error("strobe drivers clash");
    property p_bkdrv; backup_o && $past(backup_o) |-> standby_drv_oe_o; endproperty
    a_bkdrv: assert property (p_bkdrv) else $error("standby driver off in backup");
    property p_pre; $rose(standby_drv_oe_o) && !backup_o |-> hold_q >= 12'd748 && hold_q <= 12'd752; endproperty
    a_pre: assert property (p_pre) else $error("pretrigger length wrong");
    property p_wb; !rw_n_o |-> bank0_cycle_strobe_o && standby_drv_oe_o; endproperty
    a_wb: assert property (p_wb) else $error("write-back outside strobe");
    property p_wblen; $fell(rw_n_o) |-> ##[60:64] $rose(rw_n_o); endproperty
    a_wblen: assert property (p_wblen) else $error("write-back cut");
    property p_step; $changed(low_row_address_o) |-> low_row_address_o == $past(low_row_address_o) + 5'h01; endproperty
    a_step: assert property (p_step) else $error("row step wrong");
    property p_bkhold; mem_hold_o && $past(mem_hold_o) |-> $stable(backup_o); endproperty
    a_bkhold: assert property (p_bkhold) else $error("changeover under guard");
    property p_rd; !$past(reg_re_i) |-> reg_rdata_o == 16'h0000; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule // drbc_chk

bind drbc_top drbc_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .mem_hold_o(mem_hold_o), .backup_o(backup_o), .backup_n_o(backup_n_o),
    .low_row_address_o(low_row_address_o), .upper_address_o(upper_address_o),
    .refresh_drive_o(refresh_drive_o), .cs_n_o(cs_n_o), .rw_n_o(rw_n_o),
    .bank0_cycle_strobe_o(bank0_cycle_strobe_o), .standby_drv_oe_o(standby_drv_oe_o), .mem_drv_oe_o(mem_drv_oe_o));

// *** drbc_dram_model.sv ***
// Behavioural model of one bank of the dynamic RAM array
`timescale 1ns/1ps

module drbc_dram_model
(
    input wire clk_i,
    input wire clr_i,
    input wire strobe_i,
    input wire cs_n_i,
    input wire rw_n_i,
    input wire [4:0] row_i,
    output reg [31:0] rows_o,
    output reg [15:0] done_o
);
    reg on_q;
    reg wb_q;
    reg [4:0] row_q;
    // Row latched at strobe rise, restored at strobe fall if a write-back was seen during the strobe
    always @(posedge clk_i)
    begin
        on_q <= strobe_i;
        if (clr_i)
        begin
            rows_o <= 32'h0;
            done_o <= 16'h0;
        end
        if (strobe_i && !on_q)
        begin
            row_q <= row_i;
            wb_q <= 1'b0;
        end
        if (strobe_i && !rw_n_i && cs_n_i)
            wb_q <= 1'b1;
        if (!strobe_i && on_q && wb_q)
        begin
            rows_o[row_q] <= 1'b1;
            done_o <= done_o + 16'h1;
        end
    end
endmodule // drbc_dram_model

// *** drbc_tb.sv ***
// Self-checking bench of the refresh and backup controller
`timescale 1ns/1ps
`include "drbc_regs.vh"

module tb;
    reg clk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0;
    reg we = 1'b0;
    reg re = 1'b0;
    reg pf = 1'b0;
    reg mclk = 1'b0;
    reg bsel = 1'b0;
    reg clr = 1'b1;
    wire [15:0] rdata;
    wire hold, bk, drive, csn, rwn, s0, s1, sboe, mboe;
    wire [4:0] row;
    wire [6:0] upper;
    wire [31:0] rows;
    wire [15:0] done;
    reg [6:0] up;
    reg [4:0] r0;
    reg [1:0] m;
    integer err_total = 0;
    integer n_compared = 0;
    integer cyc = 0;
    integer t0;
    integer i;

    drbc_top #(.DIST_CYC(20'd1200), .BURST_CYC(20'd30000)) dut (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .power_fail_i(pf), .mem_clk_i(mclk), .bank_sel_i(bsel), .mem_hold_o(hold), .backup_o(bk),
        .backup_n_o(), .low_row_address_o(row), .upper_address_o(upper), .refresh_drive_o(drive),
        .cs_n_o(csn), .rw_n_o(rwn), .bank0_cycle_strobe_o(s0), .bank1_cycle_strobe_o(s1),
        .standby_drv_oe_o(sboe), .mem_drv_oe_o(mboe));
    drbc_dram_model u_ram (.clk_i(clk_i), .clr_i(clr), .strobe_i(s0), .cs_n_i(csn), .rw_n_i(rwn),
        .row_i(row), .rows_o(rows), .done_o(done));

    // Clock and cycle ceiling
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_total = err_total + 1;
            test_done;
        end
    end

    // --------
    // Bus, compare and closing tasks
    // --------
    function [4:0] nxt(input [4:0] a, input [4:0] n);
        nxt = a + n;
    endfunction
    task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            err_total = err_total + 1;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    end
    endtask
    task wr(input [3:0] a, input [15:0] d);
    begin
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
        @(posedge clk_i);
    end
    endtask
    task rc(input [3:0] a, input [15:0] e, input string nm);
    begin
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1;
        chk(nm, e, rdata);
        @(posedge clk_i);
    end
    endtask
    task mpulse;
    begin
        mclk <= 1'b1;
        repeat (4) @(posedge clk_i);
        mclk <= 1'b0;
        repeat (4) @(posedge clk_i);
    end
    endtask
    task test_done;
    begin
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    // --------
    // Main sequence
    // --------
    initial
    begin
        void'($urandom(68));
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        clr <= 1'b0;
        @(posedge clk_i);
        up = 7'($urandom);
        rc(`DRBC_REG_CTRL, 16'h0000, "ctrl");
        rc(`DRBC_REG_ABORTS, 16'h0000, "aborts");
        wr(`DRBC_REG_UPPER, {9'h0, up});
        wr(`DRBC_REG_STATUS, 16'hFFFF);
        wr(4'hF, 16'hFFFF);
        rc(`DRBC_REG_UPPER, {9'h0, up}, "upper");
        rc(`DRBC_REG_STATUS, 16'h0000, "status");
        rc(4'hF, 16'h0000, "unmapped");
        $display("registers done");
        // Distributed refresh
        wr(`DRBC_REG_CTRL, 16'h0001);
        @(posedge clk_i iff hold === 1'b1);
        t0 = cyc;
        @(posedge clk_i iff rwn === 1'b0);
        chk("upper pins", up, upper);
        chk("refresh drive", 1, drive);
        chk("both banks", 2'b11, {s1, s0});
        @(posedge clk_i iff hold === 1'b0);
        @(posedge clk_i iff hold === 1'b1);
        chk("interval", 1200, cyc - t0);
        @(posedge clk_i iff hold === 1'b0);
        repeat (3) @(posedge clk_i);
        chk("rows", 32'h3, rows);
        rc(`DRBC_REG_STATUS, 16'h0200, "status row");
        // Memory cycles go only to the addressed bank
        for (i = 0; i < 4; i = i + 1)
        begin
            bsel <= i[0];
            m = 2'b00;
            mclk <= 1'b1;
            repeat (8)
            begin
                @(posedge clk_i);
                m = m | {s1, s0};
            end
            chk("bank strobes", {i[0], !i[0]}, m);
            chk("mem driver", 1, mboe);
            mclk <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        $display("distributed done");
        // Abort at a random point before write-back starts, then too late
        @(posedge clk_i iff hold === 1'b1);
        repeat ($urandom % 810) @(posedge clk_i);
        wr(`DRBC_REG_CTRL, 16'h0005);
        @(posedge clk_i iff hold === 1'b0);
        repeat (3) @(posedge clk_i);
        chk("aborted row", 2, row);
        rc(`DRBC_REG_ABORTS, 16'h0001, "aborts");
        @(posedge clk_i iff rwn === 1'b0);
        wr(`DRBC_REG_CTRL, 16'h0005);
        @(posedge clk_i iff hold === 1'b0);
        repeat (3) @(posedge clk_i);
        chk("late abort row", 3, row);
        chk("write-backs", 3, done);
        rc(`DRBC_REG_ABORTS, 16'h0001, "aborts");
        $display("abort done");
        // Power fail inside a refresh waits for the guard
        @(posedge clk_i iff hold === 1'b1);
        pf <= 1'b1;
        mpulse;
        chk("backup held", 0, bk);
        @(posedge clk_i iff hold === 1'b0);
        repeat (2) @(posedge clk_i);
        mpulse;
        chk("backup", 1, bk);
        chk("standby driver", 1, sboe);
        chk("mem driver", 0, mboe);
        @(posedge clk_i iff rwn === 1'b0);
        chk("backup refresh", 2'b11, {s1, s0});
        pf <= 1'b0;
        @(posedge clk_i iff hold === 1'b0);
        repeat (2) @(posedge clk_i);
        mpulse;
        chk("restored", 0, bk);
        chk("mem driver", 1, mboe);
        $display("backup done");
        // Burst refresh covers all rows and wraps the counter
        wr(`DRBC_REG_CTRL, 16'h0000);
        @(posedge clk_i iff hold === 1'b0);
        repeat (20) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wr(`DRBC_REG_CTRL, 16'h0003);
        @(posedge clk_i iff hold === 1'b1);
        t0 = cyc;
        r0 = row;
        for (i = 0; i < 31; i = i + 1)
        begin
            @(posedge clk_i iff hold === 1'b0);
            @(posedge clk_i iff hold === 1'b1);
        end
        // Each burst cycle is pretrigger, strobe and one idle start cycle
        chk("burst span", 31 * (`DRBC_PRE_CYC + `DRBC_STB_CYC + 1), cyc - t0);
        @(posedge clk_i iff hold === 1'b0);
        repeat (3) @(posedge clk_i);
        chk("burst rows", 32'hFFFFFFFF, rows);
        chk("wrapped row", nxt(r0, 5'd0), row);
        $display("burst done");
        test_done;
    end
endmodule // tb
